// ### src/bus_defs.svh
// Widths, decode constants and wait timing for the backplane slot bus
`ifndef BUS_DEFS_SVH
`define BUS_DEFS_SVH
`define ADDR_W 24
`define ADDR_LOW_W 16
`define DATA_W 16
`define BYTE_W 8
`define ADDR_PULLUP 8'hFF
`define BYTE_FLOAT 8'hFF
`define CARD_MEM_AW 8
`define CARD_MEM_DEPTH 256
`define CARD_ROM_AW 6
`define CARD_IO_PORT 8'h40
`define CARD_WAIT 2'h2
`endif

// ### src/bus_pkg.sv
// Cycle kinds and processor sequencer states for the slot bus
package bus_pkg;
   typedef enum logic [2:0] {CYC_MEM_RD, CYC_MEM_WR, CYC_IO_RD, CYC_IO_WR, CYC_REFRESH}
      cycle_kind_t;
   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_STROBE, ST_DONE, ST_RELEASE, ST_GRANTED}
      cpu_state_t;
endpackage

// ### src/backplane_if.sv
// Backplane wiring: resolves tri-state and open-drain lines from their enables
`timescale 1ns/100ps
`default_nettype none
`include "bus_defs.svh"
interface backplane_if (
   input wire logic clk,
   input wire logic reset
);
   logic [`ADDR_W-1:0] addr_out, addr;
   logic [1:0]         addr_oe_n;
   logic [`DATA_W-1:0] data_cpu_out, data_card_out, data;
   logic [1:0]         data_cpu_oe_n, data_card_oe_n;
   logic               ctrl_oe_n;
   logic               mem_request_out, io_request_out, read_strobe_out, write_strobe_out;
   logic               mem_request_n, io_request_n, read_strobe_n, write_strobe_n;
   logic               refresh_n, halted_n, bus_grant_n, opcode_fetch_n, rw_dir;
   logic               rom_shadow_select, serial_out, serial_in;
   logic               bus_request_out, bus_request_oe_n, bus_request_n;
   logic               irq_out, irq_oe_n, maskable_irq_n;
   logic               nmi_out, nmi_oe_n, nonmaskable_irq_n;
   logic               hold_out, hold_oe_n, hold_off_n;
   logic               dma_grant_in_n, dma_grant_out_n, irq_enable_in, irq_enable_out;

   // Floated address lines are pulled high
   assign addr[`ADDR_LOW_W-1:0] = addr_oe_n[0] ? '1 : addr_out[`ADDR_LOW_W-1:0]; // RULE22
   assign addr[`ADDR_W-1:`ADDR_LOW_W] = addr_oe_n[1] ? `ADDR_PULLUP
                                                     : addr_out[`ADDR_W-1:`ADDR_LOW_W]; // RULE22
   genvar b;
   generate
      for (b = 0; b < 2; b++)
      begin : lane
         // Undriven lanes float; modelled as high so nothing reads unknown
         assign data[b*`BYTE_W +: `BYTE_W] =
            !data_cpu_oe_n[b] ? data_cpu_out[b*`BYTE_W +: `BYTE_W] :
            !data_card_oe_n[b] ? data_card_out[b*`BYTE_W +: `BYTE_W] : `BYTE_FLOAT; // RULE4
      end
   endgenerate
   assign mem_request_n  = ctrl_oe_n ? 1'h1 : mem_request_out;
   assign io_request_n   = ctrl_oe_n ? 1'h1 : io_request_out;
   assign read_strobe_n  = ctrl_oe_n ? 1'h1 : read_strobe_out;
   assign write_strobe_n = ctrl_oe_n ? 1'h1 : write_strobe_out;
   // Open-drain lines with pull-ups; further cards would AND in here
   assign bus_request_n     = bus_request_oe_n ? 1'h1 : bus_request_out;
   assign maskable_irq_n    = irq_oe_n ? 1'h1 : irq_out; // RULE6
   assign nonmaskable_irq_n = nmi_oe_n ? 1'h1 : nmi_out;
   assign hold_off_n        = hold_oe_n ? 1'h1 : hold_out;
   // Single slot: card sits first on both chains
   assign dma_grant_in_n = bus_grant_n;
   assign irq_enable_in  = 1'h1;

   modport cpu (
      input  clk, reset, data, bus_request_n, maskable_irq_n, nonmaskable_irq_n,
      input  hold_off_n, serial_in,
      output addr_out, addr_oe_n, data_cpu_out, data_cpu_oe_n, ctrl_oe_n,
      output mem_request_out, io_request_out, read_strobe_out, write_strobe_out,
      output refresh_n, halted_n, bus_grant_n, opcode_fetch_n, rw_dir,
      output rom_shadow_select, serial_out
   );
   modport card (
      input  clk, reset, addr, data, mem_request_n, io_request_n, read_strobe_n,
      input  write_strobe_n, refresh_n, rom_shadow_select, dma_grant_in_n,
      input  irq_enable_in, serial_out,
      output data_card_out, data_card_oe_n, bus_request_out, bus_request_oe_n,
      output irq_out, irq_oe_n, nmi_out, nmi_oe_n, hold_out, hold_oe_n,
      output dma_grant_out_n, irq_enable_out, serial_in
   );
endinterface
`default_nettype wire

// ### src/fall_detect.sv
// Falling-edge detector for a synchronous active-low line
`timescale 1ns/100ps
`default_nettype none
module fall_detect (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic level,
   output logic      fall
);
   logic prev_reg;

   // Starts high so a line held low at reset counts as an edge
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         prev_reg <= 1'h1;
      else
         prev_reg <= level;
   end
   assign fall = prev_reg & ~level;
endmodule
`default_nettype wire

// ### src/processor_card.sv
// Processor card end of the slot bus: bus master cycles, release and grant
// Notes on behaviour
// RULE1 - Drive tri-state 24-bit address, 16 normally used
// RULE2 - Grant bus only after all drivers released
// RULE3 - Would-be master pulls bus request low
// RULE4 - Tri-state 16-bit data bus, upper byte optional
// RULE5 - Halted low from halt until interrupt
// RULE6 - Maskable interrupt wired-OR with pull-up
// RULE7 - I/O request strobe marks separate I/O space
// RULE8 - Opcode fetch line held high, not supported
// RULE9 - Memory request only while address valid
// RULE10 - Nonmaskable interrupt latched on falling edge
// RULE11 - Low enables boot ROM, high enables RAM
// RULE12 - Read strobe low requests returned data
// RULE13 - Write strobe low while presenting data
// RULE14 - Refresh low during refresh cycles only
// RULE15 - Insert waits while hold-off stays low
// RULE16 - Serial out to terminal, serial in back
// RULE17 - DMA grant passes down daisy-chain
// RULE18 - Enable out high if enable in, not requesting
// RULE19 - Direction line high read, low write
// RULE20 - Legacy cards use legacy pins and timing; legacy_mode only narrows address and data here, cycle timing is unchanged
// RULE21 - Over four chain cards need lookahead
// RULE22 - Undriven upper address lines pulled high
`timescale 1ns/100ps
`default_nettype none
`include "bus_defs.svh"
module processor_card (
   backplane_if.cpu                 bus,
   input  wire logic                req_valid,
   output logic                     req_ready,
   input  var bus_pkg::cycle_kind_t req_kind,
   input  wire logic [`ADDR_W-1:0]  req_addr,
   input  wire logic [`DATA_W-1:0]  req_wdata,
   input  wire logic                req_wide,
   input  wire logic                legacy_mode,
   output logic                     rsp_valid,
   output logic [`DATA_W-1:0]       rsp_rdata,
   input  wire logic                rom_shadow,
   input  wire logic                halt_req,
   output logic                     halted,
   output logic                     irq_level,
   output logic                     nmi_pending,
   input  wire logic                nmi_ack,
   output logic                     bus_released,
   input  wire logic                uart_tx,
   output logic                     uart_rx
);
   bus_pkg::cpu_state_t  state_reg, state_next;
   bus_pkg::cycle_kind_t kind_reg, kind_next;
   logic [`ADDR_W-1:0]   addr_reg;
   logic [`DATA_W-1:0]   data_reg;
   logic                 wide_reg, legacy_reg, rw_reg, grant_n_reg;
   logic                 mreq_n_reg, ioreq_n_reg, rd_n_reg, wr_n_reg, rfsh_n_reg;
   logic                 halted_reg, nmi_reg, page_reg, ser_out_reg;
   logic                 accept, in_cycle, is_mem, is_read, is_write, writing;
   logic                 released, nmi_fall;
   logic                 clk, reset;

   assign clk = bus.clk;
   assign reset = bus.reset;

   assign req_ready = (state_reg == bus_pkg::ST_IDLE) & bus.bus_request_n & ~halted_reg;
   assign accept = req_valid & req_ready;
   assign kind_next = accept ? req_kind : kind_reg;
   assign is_mem = kind_next inside {bus_pkg::CYC_MEM_RD, bus_pkg::CYC_MEM_WR,
                                     bus_pkg::CYC_REFRESH};
   assign is_read = kind_next inside {bus_pkg::CYC_MEM_RD, bus_pkg::CYC_IO_RD};
   assign is_write = kind_next inside {bus_pkg::CYC_MEM_WR, bus_pkg::CYC_IO_WR};

   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         bus_pkg::ST_IDLE:
            if (!bus.bus_request_n)
               state_next = bus_pkg::ST_RELEASE; // RULE3
            else if (accept)
               state_next = bus_pkg::ST_ADDR;
         bus_pkg::ST_ADDR:
            state_next = bus_pkg::ST_STROBE;
         bus_pkg::ST_STROBE:
            if (bus.hold_off_n)
               state_next = bus_pkg::ST_DONE; // RULE15
         bus_pkg::ST_DONE:
            state_next = bus_pkg::ST_IDLE;
         bus_pkg::ST_RELEASE:
            state_next = bus_pkg::ST_GRANTED;
         bus_pkg::ST_GRANTED:
            if (bus.bus_request_n)
               state_next = bus_pkg::ST_IDLE;
         default:
            state_next = bus_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         state_reg <= bus_pkg::ST_IDLE;
         kind_reg <= bus_pkg::CYC_MEM_RD;
      end
      else
      begin
         state_reg <= state_next;
         kind_reg <= kind_next;
      end
   end

   // Strobes are registered from the next state so they line up with it
   assign in_cycle = (state_next == bus_pkg::ST_ADDR) | (state_next == bus_pkg::ST_STROBE);
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         mreq_n_reg <= 1'h1;
         ioreq_n_reg <= 1'h1;
         rd_n_reg <= 1'h1;
         wr_n_reg <= 1'h1;
         rfsh_n_reg <= 1'h1;
      end
      else
      begin
         mreq_n_reg <= ~(in_cycle & is_mem); // RULE9
         ioreq_n_reg <= ~(in_cycle & ~is_mem); // RULE7
         rd_n_reg <= ~((state_next == bus_pkg::ST_STROBE) & is_read); // RULE12
         wr_n_reg <= ~((state_next == bus_pkg::ST_STROBE) & is_write); // RULE13
         rfsh_n_reg <= ~(in_cycle & (kind_next == bus_pkg::CYC_REFRESH)); // RULE14
      end
   end

   // Legacy is caught per cycle so widths never change mid-transfer
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         addr_reg <= '0;
         data_reg <= '0;
         wide_reg <= 1'h0;
         legacy_reg <= 1'h0;
         rw_reg <= 1'h1;
      end
      else if (accept)
      begin
         addr_reg <= req_addr; // RULE1
         data_reg <= req_wdata;
         wide_reg <= req_wide;
         legacy_reg <= legacy_mode; // RULE20
         rw_reg <= ~is_write; // RULE19
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         rsp_valid <= 1'h0;
         rsp_rdata <= '0;
      end
      else
      begin
         rsp_valid <= (state_reg == bus_pkg::ST_STROBE) & bus.hold_off_n;
         if ((state_reg == bus_pkg::ST_STROBE) & bus.hold_off_n)
            rsp_rdata <= (wide_reg & ~legacy_reg) ? bus.data
                         : {{`BYTE_W{1'h0}}, bus.data[`BYTE_W-1:0]}; // RULE4
      end
   end

   // Drivers float a full cycle before the grant goes low
   assign released = (state_reg == bus_pkg::ST_RELEASE) | (state_reg == bus_pkg::ST_GRANTED);
   assign writing = (kind_reg inside {bus_pkg::CYC_MEM_WR, bus_pkg::CYC_IO_WR}) &
                    (state_reg inside {bus_pkg::ST_ADDR, bus_pkg::ST_STROBE, bus_pkg::ST_DONE});
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         grant_n_reg <= 1'h1;
      else
         grant_n_reg <= ~(state_next == bus_pkg::ST_GRANTED); // RULE2
   end

   assign bus.ctrl_oe_n = released; // RULE2
   assign bus.addr_oe_n = {released | legacy_reg, released}; // RULE22
   assign bus.addr_out = addr_reg;
   assign bus.data_cpu_out = data_reg;
   assign bus.data_cpu_oe_n = {~(writing & wide_reg & ~legacy_reg), ~writing}; // RULE4
   assign bus.mem_request_out = mreq_n_reg;
   assign bus.io_request_out = ioreq_n_reg;
   assign bus.read_strobe_out = rd_n_reg;
   assign bus.write_strobe_out = wr_n_reg;
   assign bus.refresh_n = rfsh_n_reg;
   assign bus.bus_grant_n = grant_n_reg;
   assign bus.rw_dir = rw_reg;
   assign bus.opcode_fetch_n = 1'h1; // RULE8
   assign bus_released = state_reg == bus_pkg::ST_GRANTED;

   fall_detect nmi_edge (
      .clk   (clk),
      .reset (reset),
      .level (bus.nonmaskable_irq_n),
      .fall  (nmi_fall)
   );

   // A new halt or edge in the clearing cycle wins over the clear
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         halted_reg <= 1'h0;
         nmi_reg <= 1'h0;
      end
      else
      begin
         halted_reg <= halt_req | (halted_reg & bus.maskable_irq_n & ~nmi_fall); // RULE5
         nmi_reg <= nmi_fall | (nmi_reg & ~nmi_ack); // RULE10
      end
   end
   assign bus.halted_n = ~halted_reg;
   assign halted = halted_reg;
   assign nmi_pending = nmi_reg;
   assign irq_level = ~bus.maskable_irq_n; // RULE6

   // ROM is mapped in from reset; serial lines idle at mark
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         page_reg <= 1'h0;
         ser_out_reg <= 1'h1;
         uart_rx <= 1'h1;
      end
      else
      begin
         page_reg <= rom_shadow; // RULE11
         ser_out_reg <= uart_tx; // RULE16
         uart_rx <= bus.serial_in;
      end
   end
   assign bus.rom_shadow_select = page_reg;
   assign bus.serial_out = ser_out_reg;
endmodule
`default_nettype wire

// ### src/slot_card.sv
// Peripheral card end: memory with boot ROM overlay, I/O port, chains, DMA
`timescale 1ns/100ps
`default_nettype none
`include "bus_defs.svh"
module slot_card (
   backplane_if.card               bus,
   input  wire logic [`BYTE_W-1:0] io_status,
   output logic [`BYTE_W-1:0]      io_ctrl,
   input  wire logic               irq_raise,
   input  wire logic               irq_ack,
   output logic                    irq_pending,
   input  wire logic               nmi_request,
   input  wire logic               dma_want,
   output logic                    dma_granted,
   input  wire logic               term_tx,
   output logic                    term_rx
);
   logic [`DATA_W-1:0] ram [0:`CARD_MEM_DEPTH-1];
   logic [`DATA_W-1:0] data_reg, rd_word;
   logic [1:0]         cnt_reg;
   logic               ready_reg, irq_reg, ser_in_reg;
   logic               mem_sel, rom_hit, io_sel, active, do_write;

   function automatic logic [`DATA_W-1:0] rom_word(input logic [`CARD_ROM_AW-1:0] a);
      rom_word = {2'h0, a, 2'h3, a};
   endfunction

   // Only the low 16 lines decode; 8-bit processors drive no more
   assign mem_sel = !bus.mem_request_n & bus.refresh_n &
                    (bus.addr[`ADDR_LOW_W-1:`CARD_MEM_AW] == '0);
   assign rom_hit = mem_sel & !bus.rom_shadow_select &
                    (bus.addr[`CARD_MEM_AW-1:`CARD_ROM_AW] == '0); // RULE11
   assign io_sel = !bus.io_request_n & (bus.addr[`BYTE_W-1:0] == `CARD_IO_PORT);
   assign active = (mem_sel | io_sel) & (!bus.read_strobe_n | !bus.write_strobe_n);
   assign do_write = active & !ready_reg & (cnt_reg == `CARD_WAIT) & !bus.write_strobe_n;
   assign rd_word = io_sel ? {{`BYTE_W{1'h0}}, io_status}
                  : rom_hit ? rom_word(bus.addr[`CARD_ROM_AW-1:0])
                  : ram[bus.addr[`CARD_MEM_AW-1:0]];

   // Fixed wait count gives the read word time to settle in data_reg
   always_ff @(posedge bus.clk or posedge bus.reset)
   begin
      if (bus.reset)
      begin
         cnt_reg <= 2'h0;
         ready_reg <= 1'h0;
         data_reg <= '0;
      end
      else if (!active)
      begin
         cnt_reg <= 2'h0;
         ready_reg <= 1'h0;
      end
      else if (!ready_reg)
      begin
         if (cnt_reg == 2'h0)
            data_reg <= rd_word;
         if (cnt_reg == `CARD_WAIT)
            ready_reg <= 1'h1; // RULE15
         else
            cnt_reg <= cnt_reg + 2'h1;
      end
   end

   // RAM under an enabled ROM is switched off, so such writes are dropped
   always_ff @(posedge bus.clk)
   begin
      if (do_write & mem_sel & !rom_hit)
         ram[bus.addr[`CARD_MEM_AW-1:0]] <= bus.data; // RULE11
   end

   always_ff @(posedge bus.clk or posedge bus.reset)
   begin
      if (bus.reset)
         io_ctrl <= '0;
      else if (do_write & io_sel)
         io_ctrl <= bus.data[`BYTE_W-1:0];
   end

   assign bus.hold_out = 1'h0;
   assign bus.hold_oe_n = ~(active & !ready_reg); // RULE15
   assign bus.data_card_out = data_reg;
   assign bus.data_card_oe_n = {2{~(active & !bus.read_strobe_n)}}; // RULE4

   // Raise in the acknowledge cycle keeps the request
   always_ff @(posedge bus.clk or posedge bus.reset)
   begin
      if (bus.reset)
         irq_reg <= 1'h0;
      else
         irq_reg <= irq_raise | (irq_reg & ~irq_ack);
   end
   assign irq_pending = irq_reg;
   assign bus.irq_out = 1'h0;
   assign bus.irq_oe_n = ~irq_reg; // RULE6
   assign bus.irq_enable_out = bus.irq_enable_in & ~irq_reg; // RULE18
   assign bus.nmi_out = 1'h0;
   assign bus.nmi_oe_n = ~nmi_request;

   assign bus.bus_request_out = 1'h0;
   assign bus.bus_request_oe_n = ~dma_want; // RULE3
   assign dma_granted = dma_want & !bus.dma_grant_in_n; // RULE17
   assign bus.dma_grant_out_n = bus.dma_grant_in_n | dma_want; // RULE17

   always_ff @(posedge bus.clk or posedge bus.reset)
   begin
      if (bus.reset)
      begin
         ser_in_reg <= 1'h1;
         term_rx <= 1'h1;
      end
      else
      begin
         ser_in_reg <= term_tx; // RULE16
         term_rx <= bus.serial_out;
      end
   end
   assign bus.serial_in = ser_in_reg;
endmodule
`default_nettype wire

// ### tb/backplane_slot_bus_interface_properties.sv
// Concurrent checks on the slot bus wires between processor and card
`timescale 1ns/100ps
`default_nettype none
module backplane_slot_bus_interface_properties (
   input wire logic       clk,
   input wire logic       reset,
   input wire logic [1:0] addr_oe_n,
   input wire logic [1:0] data_cpu_oe_n,
   input wire logic       ctrl_oe_n,
   input wire logic       mem_request_n,
   input wire logic       io_request_n,
   input wire logic       read_strobe_n,
   input wire logic       write_strobe_n,
   input wire logic       refresh_n,
   input wire logic       halted_n,
   input wire logic       bus_grant_n,
   input wire logic       opcode_fetch_n,
   input wire logic       rw_dir,
   input wire logic       bus_request_n,
   input wire logic       maskable_irq_n,
   input wire logic       nonmaskable_irq_n,
   input wire logic       hold_off_n,
   input wire logic       dma_grant_in_n,
   input wire logic       dma_grant_out_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   sequence strobe_on;
      !read_strobe_n || !write_strobe_n;
   endsequence
   sequence card_waits;
      !hold_off_n ##0 strobe_on;
   endsequence

   grant_released_a: assert property (
      !bus_grant_n |-> ctrl_oe_n && addr_oe_n == 2'h3 && data_cpu_oe_n == 2'h3)
      else $error("grant given while bus still driven");
   grant_follows_a: assert property ($fell(bus_request_n) |-> ##[1:10] !bus_grant_n)
      else $error("bus request not granted in time");
   grant_returns_a: assert property (bus_request_n && !bus_grant_n |=> bus_grant_n)
      else $error("grant held after request withdrawn");
   request_exclusive_a: assert property (!mem_request_n |-> io_request_n)
      else $error("memory and io request together");
   refresh_only_a: assert property (
      !refresh_n |-> !mem_request_n && read_strobe_n && write_strobe_n)
      else $error("refresh cycle carries a transfer");
   read_cycle_a: assert property (
      !read_strobe_n |-> write_strobe_n && rw_dir && (!mem_request_n || !io_request_n))
      else $error("bad read cycle qualifiers");
   write_cycle_a: assert property (
      !write_strobe_n |-> !rw_dir && (!mem_request_n || !io_request_n))
      else $error("bad write cycle qualifiers");
   wait_extends_a: assert property (card_waits |=> strobe_on)
      else $error("strobe ended while card held off");
   fetch_inactive_a: assert property (opcode_fetch_n)
      else $error("opcode fetch line driven low");
   dma_chain_a: assert property (!dma_grant_out_n |-> !dma_grant_in_n)
      else $error("dma grant passed on without grant in");
   halt_holds_a: assert property (
      !halted_n && maskable_irq_n && nonmaskable_irq_n && $past(maskable_irq_n)
      && $past(nonmaskable_irq_n) |=> !halted_n)
      else $error("halt left without interrupt");
endmodule
`default_nettype wire

// ### tb/test_backplane_slot_bus_interface.sv
// Bench joining processor card and slot card across the backplane
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
   $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module test_backplane_slot_bus_interface;
   logic                 clk, reset, req_valid, req_ready, req_wide, legacy_mode;
   logic                 rsp_valid, rom_shadow, halt_req, halted, irq_level;
   logic                 nmi_pending, nmi_ack, bus_released, uart_tx, uart_rx;
   logic                 irq_raise, irq_ack, irq_pending, nmi_request, dma_want;
   logic                 dma_granted, term_tx, term_rx;
   logic [23:0]          req_addr;
   logic [15:0]          req_wdata, rsp_rdata, rd;
   logic [7:0]           io_status, io_ctrl;
   bus_pkg::cycle_kind_t req_kind;
   int                   miscompares, n_compared, cycles, lat, n;

   backplane_if u_backplane_if (.clk(clk), .reset(reset));
   processor_card u_processor_card (.bus(u_backplane_if), .req_valid(req_valid),
      .req_ready(req_ready), .req_kind(req_kind), .req_addr(req_addr),
      .req_wdata(req_wdata), .req_wide(req_wide), .legacy_mode(legacy_mode),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rom_shadow(rom_shadow),
      .halt_req(halt_req), .halted(halted), .irq_level(irq_level),
      .nmi_pending(nmi_pending), .nmi_ack(nmi_ack), .bus_released(bus_released),
      .uart_tx(uart_tx), .uart_rx(uart_rx));
   slot_card u_slot_card (.bus(u_backplane_if), .io_status(io_status), .io_ctrl(io_ctrl),
      .irq_raise(irq_raise), .irq_ack(irq_ack), .irq_pending(irq_pending),
      .nmi_request(nmi_request), .dma_want(dma_want), .dma_granted(dma_granted),
      .term_tx(term_tx), .term_rx(term_rx));
   backplane_slot_bus_interface_properties u_props (.clk(clk), .reset(reset),
      .addr_oe_n(u_backplane_if.addr_oe_n), .data_cpu_oe_n(u_backplane_if.data_cpu_oe_n),
      .ctrl_oe_n(u_backplane_if.ctrl_oe_n), .mem_request_n(u_backplane_if.mem_request_n),
      .io_request_n(u_backplane_if.io_request_n), .read_strobe_n(u_backplane_if.read_strobe_n),
      .write_strobe_n(u_backplane_if.write_strobe_n), .refresh_n(u_backplane_if.refresh_n),
      .halted_n(u_backplane_if.halted_n), .bus_grant_n(u_backplane_if.bus_grant_n),
      .opcode_fetch_n(u_backplane_if.opcode_fetch_n), .rw_dir(u_backplane_if.rw_dir),
      .bus_request_n(u_backplane_if.bus_request_n),
      .maskable_irq_n(u_backplane_if.maskable_irq_n),
      .nonmaskable_irq_n(u_backplane_if.nonmaskable_irq_n),
      .hold_off_n(u_backplane_if.hold_off_n), .dma_grant_in_n(u_backplane_if.dma_grant_in_n),
      .dma_grant_out_n(u_backplane_if.dma_grant_out_n));

   initial
   begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   task automatic conclude;
      $display("compared %0d, miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Hang guard: whole run needs under two hundred cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         miscompares++;
         conclude();
      end
   end

   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   // Request held over one accept edge; latency counted in edges after it
   task automatic do_req(input bus_pkg::cycle_kind_t k, input logic [23:0] a,
                         input logic [15:0] wd, input logic w);
      tick(1);
      req_kind = k;
      req_addr = a;
      req_wdata = wd;
      req_wide = w;
      req_valid = 1'h1;
      tick(1);
      req_valid = 1'h0;
      lat = 0;
      while (rsp_valid !== 1'h1 && lat < 20)
      begin
         tick(1);
         lat++;
      end
      rd = rsp_rdata;
      `CHK(rsp_valid, 1'h1);
   endtask

   task automatic rom_test;
      do_req(bus_pkg::CYC_MEM_RD, 24'h000005, 16'h0000, 1'h1);
      `CHK(rd, 16'h05C5);
      do_req(bus_pkg::CYC_MEM_WR, 24'h000005, 16'h1234, 1'h1);
      do_req(bus_pkg::CYC_MEM_RD, 24'h000005, 16'h0000, 1'h1);
      `CHK(rd, 16'h05C5);
      rom_shadow = 1'h1;
      tick(2);
      do_req(bus_pkg::CYC_MEM_WR, 24'h000005, 16'h1234, 1'h1);
      do_req(bus_pkg::CYC_MEM_RD, 24'h000005, 16'h0000, 1'h1);
      `CHK(rd, 16'h1234);
   endtask

   task automatic mem_test;
      do_req(bus_pkg::CYC_MEM_WR, 24'h000080, 16'hA55A, 1'h1);
      `CHK(lat, 5);
      do_req(bus_pkg::CYC_MEM_RD, 24'h000080, 16'h0000, 1'h1);
      `CHK(rd, 16'hA55A);
      `CHK(lat, 5);
      do_req(bus_pkg::CYC_MEM_RD, 24'h000080, 16'h0000, 1'h0);
      `CHK(rd, 16'h005A);
      legacy_mode = 1'h1;
      do_req(bus_pkg::CYC_MEM_RD, 24'h000080, 16'h0000, 1'h1);
      `CHK(rd, 16'h005A);
      `CHK(u_backplane_if.addr, 24'hFF0080);
      legacy_mode = 1'h0;
      do_req(bus_pkg::CYC_REFRESH, 24'h000080, 16'hFFFF, 1'h1);
      `CHK(lat, 2);
      do_req(bus_pkg::CYC_MEM_RD, 24'h000080, 16'h0000, 1'h1);
      `CHK(rd, 16'hA55A);
      do_req(bus_pkg::CYC_MEM_RD, 24'h001000, 16'h0000, 1'h1);
      `CHK(rd, 16'hFFFF);
      `CHK(lat, 2);
   endtask

   task automatic io_test;
      do_req(bus_pkg::CYC_IO_WR, 24'h000040, 16'h003C, 1'h0);
      `CHK(io_ctrl, 8'h3C);
      do_req(bus_pkg::CYC_IO_RD, 24'h000040, 16'h0000, 1'h0);
      `CHK(rd, 16'h00C3);
      do_req(bus_pkg::CYC_IO_WR, 24'h000041, 16'h0099, 1'h0);
      `CHK(io_ctrl, 8'h3C);
      `CHK(lat, 2);
   endtask

   task automatic grant_test;
      dma_want = 1'h1;
      n = 0;
      while (dma_granted !== 1'h1 && n < 10)
      begin
         tick(1);
         n++;
      end
      `CHK(u_backplane_if.bus_grant_n, 1'h0);
      `CHK(bus_released, 1'h1);
      `CHK(req_ready, 1'h0);
      `CHK(u_backplane_if.addr, 24'hFFFFFF);
      `CHK(u_backplane_if.data, 16'hFFFF);
      `CHK(u_backplane_if.dma_grant_out_n, 1'h1);
      `CHK(dma_granted, 1'h1);
      dma_want = 1'h0;
      tick(2);
      `CHK(u_backplane_if.bus_grant_n, 1'h1);
      `CHK(req_ready, 1'h1);
   endtask

   task automatic halt_irq_test;
      halt_req = 1'h1;
      tick(1);
      halt_req = 1'h0;
      tick(4);
      `CHK(halted, 1'h1);
      `CHK(u_backplane_if.halted_n, 1'h0);
      irq_raise = 1'h1;
      tick(1);
      irq_raise = 1'h0;
      tick(3);
      `CHK(irq_level, 1'h1);
      `CHK(u_backplane_if.irq_enable_out, 1'h0);
      `CHK(irq_pending, 1'h1);
      `CHK(halted, 1'h0);
      irq_ack = 1'h1;
      tick(1);
      irq_ack = 1'h0;
      tick(2);
      `CHK(irq_level, 1'h0);
      `CHK(u_backplane_if.irq_enable_out, 1'h1);
      `CHK(irq_pending, 1'h0);
   endtask

   task automatic nmi_test;
      nmi_request = 1'h1;
      tick(3);
      `CHK(nmi_pending, 1'h1);
      nmi_ack = 1'h1;
      tick(1);
      nmi_ack = 1'h0;
      tick(3);
      `CHK(nmi_pending, 1'h0);
      nmi_request = 1'h0;
      tick(2);
      nmi_request = 1'h1;
      tick(3);
      `CHK(nmi_pending, 1'h1);
      nmi_request = 1'h0;
      nmi_ack = 1'h1;
      tick(1);
      nmi_ack = 1'h0;
   endtask

   task automatic serial_test;
      term_tx = 1'h0;
      uart_tx = 1'h0;
      tick(3);
      `CHK(uart_rx, 1'h0);
      `CHK(term_rx, 1'h0);
      term_tx = 1'h1;
      uart_tx = 1'h1;
      tick(3);
      `CHK(uart_rx, 1'h1);
      `CHK(term_rx, 1'h1);
   endtask

   initial
   begin
      {req_valid, req_wide, legacy_mode, rom_shadow, halt_req, nmi_ack} = '0;
      {irq_raise, irq_ack, nmi_request, dma_want} = '0;
      {uart_tx, term_tx} = 2'h3;
      req_kind = bus_pkg::CYC_MEM_RD;
      req_addr = 24'h000000;
      req_wdata = 16'h0000;
      io_status = 8'hC3;
      reset = 1'h1;
      tick(20);
      reset = 1'h0;
      rom_test();
      mem_test();
      io_test();
      grant_test();
      halt_irq_test();
      nmi_test();
      serial_test();
      conclude();
   end
endmodule
`default_nettype wire
